// ---- kms_debounce.sv ----
// Frame debouncer: a scan frame is accepted once it repeats a programmed number of times.
`timescale 1ns/1ps

module kms_debounce #(
	parameter int WIDTH = 72,
	parameter int CNT_W = 4
) (
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	// Raw frames
	input  wire logic             frame_i,
	input  wire logic [WIDTH-1:0] raw_i,
	input  wire logic [CNT_W-1:0] count_i,
	// Accepted frame
	output logic      [WIDTH-1:0] stable_o,
	output logic                  update_o
);

	logic [WIDTH-1:0] last_reg;
	logic [CNT_W-1:0] cnt_reg;

	// Count identical frames; a change restarts the count.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_reg <= '0;
			cnt_reg  <= '0;
			stable_o <= '0;
			update_o <= 1'b0;
		end else begin
			update_o <= 1'b0;
			if (frame_i) begin
				if (raw_i != last_reg) begin
					last_reg <= raw_i;
					cnt_reg  <= '0;
				end else if (cnt_reg != count_i) begin
					cnt_reg <= cnt_reg + 1'b1;
				end else begin
					stable_o <= raw_i;
					update_o <= 1'b1;
				end
			end
		end
	end

endmodule : kms_debounce

// ---- kms_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the key matrix scanner.
`ifndef KMS_DEFINES_SVH
`define KMS_DEFINES_SVH

`define KMS_ADDR_COMBO0    8'h65
`define KMS_ADDR_COMBO1    8'h66
`define KMS_ADDR_COMBO2    8'h67
`define KMS_ADDR_KEY_DATA  8'h68
`define KMS_RD_UNMAPPED    8'h00

`define KMS_COMBO_RESET    8'hf8
`define KMS_COMBO_NONE     8'hf8
`define KMS_COMBO_ACT_MSB  7
`define KMS_COMBO_ACT_LSB  6
`define KMS_COMBO_ACT_SEL  2'b00
`define KMS_COMBO_ROW_MSB  5
`define KMS_COMBO_ROW_LSB  3
`define KMS_COMBO_COL_MSB  2
`define KMS_COMBO_COL_LSB  0

`define KMS_EVT_DOWN       1'b0
`define KMS_EVT_UP         1'b1
`define KMS_EVT_NO_KEY     8'hf8

`define KMS_SF_PHASE       4'h8
`define KMS_SF_RESET       8'hff
`define KMS_DED_RESET      3'h7

`define KMS_CLK_NS         10
`define KMS_TICK_NS        1000
`define KMS_TICK_CYC       (`KMS_TICK_NS / `KMS_CLK_NS)

`endif

// ---- kms_event_fifo.sv ----
// Small key event memory with a registered head word.
`timescale 1ns/1ps

module kms_event_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	// Write side
	input  wire logic             push_i,
	input  wire logic [WIDTH-1:0] data_i,
	output logic                  full_o,
	// Read side
	input  wire logic             pop_i,
	output logic                  valid_o,
	output logic      [WIDTH-1:0] head_o
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             push_ok;
	logic             pop_ok;

	// Full pushes are dropped; empty pops are ignored.
	assign full_o  = (count_reg == (AW+1)'(DEPTH));
	assign push_ok = push_i && !full_o;
	assign pop_ok  = pop_i && (count_reg != '0);

	// Storage array, no reset needed.
	always_ff @(posedge clock_i) begin
		if (push_ok) begin
			mem[wr_ptr_reg] <= data_i;
		end
	end

	// Pointers and fill level.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push_ok) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop_ok) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_reg + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
		end
	end

	// Registered head word and its valid flag.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			valid_o <= 1'b0;
			head_o  <= '0;
		end else begin
			valid_o <= (count_reg != '0);
			head_o  <= mem[rd_ptr_reg];
		end
	end

endmodule : kms_event_fifo

// ---- kms_keypad_model.sv ----
// Keypad matrix model: switches between rows and columns, plus keys that pull a column low alone.
`timescale 1ns/1ps

module kms_keypad_model (
	// Row pins from the scanner
	input  wire logic [7:0]  row_i,
	input  wire logic [7:0]  row_oe_n_i,
	// Key state set by the bench
	input  wire logic [63:0] key_down_i,
	input  wire logic [7:0]  line_low_i,
	// Column pins to the scanner
	output logic      [7:0]  col_o
);
	// Columns idle high through their pull-ups; a closed switch on a row driven low pulls one down.
	always_comb begin
		for (int c = 0; c < 8; c++) begin
			col_o[c] = !line_low_i[c];
			for (int r = 0; r < 8; r++)
				if (key_down_i[r*8+c] && !row_oe_n_i[r] && !row_i[r])
					col_o[c] = 1'b0;
		end
	end
endmodule : kms_keypad_model

// ---- kms_pkg.sv ----
// Types shared by the key matrix scanner files.
package kms_pkg;

	// Power mode reported by the system controller.
	typedef enum logic [1:0] {
		KMS_PWR_OPER,
		KMS_PWR_SLEEP,
		KMS_PWR_HIB
	} kms_pwr_t;

	// Event walker states.
	typedef enum logic [1:0] {
		KMS_WALK_IDLE,
		KMS_WALK_SLOT,
		KMS_WALK_NEW
	} kms_walk_t;

endpackage : kms_pkg

// ---- kms_scanner.sv ----
// Key matrix scanner: row drive, column sampling, key events, combination and wake logic.
`timescale 1ns/1ps
`include "kms_defines.svh"

module kms_scanner import kms_pkg::*; #(
	parameter int TICK_CYC   = `KMS_TICK_CYC,
	parameter int FIFO_DEPTH = 8
) (
	// Clock and reset
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	// Register port
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// Keypad configuration
	input  wire logic       scanner_clock_enable_i,
	input  wire logic       scan_enable_i,
	input  wire logic [3:0] scan_count_i,
	input  wire logic [3:0] debounce_count_i,
	input  wire logic [2:0] dedicated_key_enable_i,
	input  wire logic [7:0] column_scan_enable_i,
	input  wire logic [7:0] row_scan_enable_i,
	input  wire logic       hibernate_wake_enable_i,
	// Power mode
	input  wire logic [1:0] power_mode_i,
	// Keypad pins
	input  wire logic [7:0] col_i,
	output logic      [7:0] row_o,
	output logic      [7:0] row_oe_n_o,
	output logic      [7:0] col_pullup_o,
	output logic      [7:0] row_dir_out_o,
	// Status and wake
	output logic            irq_o,
	output logic            wake_o,
	output logic            sleep_req_o,
	output logic            hib_return_o,
	output logic      [7:0] sf_key_up_o,
	output logic      [2:0] ded_key_up_o
);

	localparam int TW = $clog2(TICK_CYC + 1);

	logic            rst_q1;
	logic            rst_n;
	logic [7:0]      combo_mask_reg [3];
	logic [63:0]     combo_bits [3];
	logic [2:0]      combo_act;
	logic [63:0]     combo_vec;
	logic            combo_hit;
	logic            combo_prev_reg;
	logic            combo_pending_reg;
	logic            combo_rise;
	logic [TW-1:0]   tick_cnt_reg;
	logic            tick_reg;
	logic [3:0]      phase_reg;
	logic [3:0]      settle_reg;
	logic [63:0]     frame_raw_reg;
	logic [7:0]      sf_raw_reg;
	logic            frame_done_reg;
	logic [71:0]     stable;
	logic            upd;
	logic [63:0]     eff;
	logic [7:0]      col_low;
	logic [7:0]      mat_cols;
	logic            scanning;
	logic            in_hib;
	logic            in_sleep;
	logic [7:0]      drive_mask;
	kms_walk_t       walk_reg;
	logic [5:0]      idx_reg;
	logic [63:0]     eff_snap_reg;
	logic [7:0]      sf_snap_reg;
	logic [2:0]      slot_vld_reg;
	logic [5:0]      slot_key_reg [3];
	logic [5:0]      sk;
	logic            push;
	logic [7:0]      push_data;
	logic            in_slot;
	logic            free_hit;
	logic [1:0]      free_sel;
	logic            fifo_full;
	logic            fifo_valid;
	logic [7:0]      fifo_head;
	logic            advance;
	logic            key_down_evt;
	logic            data_rd;
	logic            hib_probe_reg;

	// Reset release through two flip-flops.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n  <= rst_q1;
		end
	end

	assign col_low  = ~col_i & column_scan_enable_i;
	assign mat_cols = col_low & ~{5'h00, dedicated_key_enable_i};
	assign scanning = scanner_clock_enable_i && scan_enable_i;
	assign in_hib   = (power_mode_i == KMS_PWR_HIB);
	assign in_sleep = (power_mode_i == KMS_PWR_SLEEP);
	assign eff      = stable[63:0] & ~{8{stable[71:64]}};

	// Base tick divider for the scan sequencer.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= '0;
			tick_reg     <= 1'b0;
		end else if (!scanning || tick_cnt_reg == TW'(TICK_CYC - 1)) begin
			tick_cnt_reg <= '0;
			tick_reg     <= scanning;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 1'b1;
			tick_reg     <= 1'b0;
		end
	end

	// settle ticks per row from the scan count; a ninth phase reads special keys.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg      <= '0;
			settle_reg     <= '0;
			frame_raw_reg  <= '0;
			sf_raw_reg     <= '0;
			frame_done_reg <= 1'b0;
		end else begin
			frame_done_reg <= 1'b0;
			if (!scanning) begin
				phase_reg  <= '0;
				settle_reg <= '0;
			end else if (tick_reg) begin
				if (settle_reg < scan_count_i) begin
					settle_reg <= settle_reg + 1'b1;
				end else begin
					settle_reg <= '0;
					if (phase_reg == `KMS_SF_PHASE) begin
						sf_raw_reg     <= mat_cols;
						phase_reg      <= '0;
						frame_done_reg <= 1'b1;
					end else begin
						frame_raw_reg[{phase_reg[2:0], 3'b000} +: 8] <=
							row_scan_enable_i[phase_reg[2:0]] ? mat_cols : 8'h00;
						phase_reg <= phase_reg + 1'b1;
					end
				end
			end
		end
	end

	// all enabled rows low while hibernate wake is armed.
	always_comb begin
		drive_mask = 8'h00;
		if (in_hib && hibernate_wake_enable_i) begin
			drive_mask = 8'hff;
		end else if (scanning && phase_reg != `KMS_SF_PHASE) begin
			drive_mask = 8'h01 << phase_reg[2:0];
		end
	end

	// pin direction, pull-ups and row drive.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			row_o         <= 8'h00;
			row_oe_n_o    <= 8'hff;
			col_pullup_o  <= 8'h00;
			row_dir_out_o <= 8'h00;
		end else begin
			row_o         <= 8'h00;
			row_oe_n_o    <= ~(row_scan_enable_i & drive_mask);
			col_pullup_o  <= column_scan_enable_i;
			row_dir_out_o <= row_scan_enable_i;
		end
	end

	// Debounce the whole matrix together with the special key line.
	kms_debounce #(
		.WIDTH (72),
		.CNT_W (4)
	) u_debounce (
		.clock_i  (clock_i),
		.rst_n_i  (rst_n),
		.frame_i  (frame_done_reg),
		.raw_i    ({sf_raw_reg, frame_raw_reg}),
		.count_i  (debounce_count_i),
		.stable_o (stable),
		.update_o (upd)
	);

	// dedicated keys follow their pins whenever clocked.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			ded_key_up_o <= `KMS_DED_RESET;
			sf_key_up_o  <= `KMS_SF_RESET;
		end else if (scanner_clock_enable_i) begin
			ded_key_up_o <= ~(col_low[2:0] & dedicated_key_enable_i);
			if (upd) begin
				sf_key_up_o <= ~stable[71:64];
			end
		end
	end

	// Combination masks and their decoded key vectors.
	for (genvar i = 0; i < 3; i++) begin : g_combo
		always_ff @(posedge clock_i or negedge rst_n) begin
			if (!rst_n) begin
				combo_mask_reg[i] <= `KMS_COMBO_RESET;
			end else if (reg_wr_i && reg_addr_i == (`KMS_ADDR_COMBO0 + 8'(i))) begin
				combo_mask_reg[i] <= reg_wdata_i;
			end
		end
		assign combo_act[i] = (combo_mask_reg[i][`KMS_COMBO_ACT_MSB:`KMS_COMBO_ACT_LSB]
			== `KMS_COMBO_ACT_SEL) && (combo_mask_reg[i] != `KMS_COMBO_NONE);
		// row and column select one key.
		assign combo_bits[i] = combo_act[i] ? (64'h1 << {
			combo_mask_reg[i][`KMS_COMBO_ROW_MSB:`KMS_COMBO_ROW_LSB],
			combo_mask_reg[i][`KMS_COMBO_COL_MSB:`KMS_COMBO_COL_LSB]}) : 64'h0;
	end

	assign combo_vec  = combo_bits[0] | combo_bits[1] | combo_bits[2];
	// all programmed keys and nothing else.
	assign combo_hit  = (combo_vec != 64'h0) && ((eff & combo_vec) == combo_vec)
		&& ((eff & ~combo_vec) == 64'h0);
	assign combo_rise = upd && combo_hit && !combo_prev_reg;

	// Event walker decode: old slots first, then new presses.
	always_comb begin
		push      = 1'b0;
		push_data = `KMS_EVT_NO_KEY;
		in_slot   = 1'b0;
		free_hit  = 1'b0;
		free_sel  = 2'd0;
		sk        = slot_key_reg[idx_reg[1:0]];
		for (int k = 0; k < 3; k++) begin
			if (slot_vld_reg[k] && slot_key_reg[k] == idx_reg) begin
				in_slot = 1'b1;
			end
			if (!slot_vld_reg[k] && !free_hit) begin
				free_hit = 1'b1;
				free_sel = 2'(k);
			end
		end
		case (walk_reg)
			KMS_WALK_SLOT: begin
				if (slot_vld_reg[idx_reg[1:0]] && !eff_snap_reg[sk]) begin
					push      = 1'b1;
					push_data = sf_snap_reg[sk[2:0]] ? `KMS_EVT_NO_KEY
						: {`KMS_EVT_UP, 1'b0, sk};
				end
			end
			KMS_WALK_NEW: begin
				// new press while a slot is free.
				if (eff_snap_reg[idx_reg] && !in_slot && free_hit) begin
					push      = 1'b1;
					push_data = {`KMS_EVT_DOWN, 1'b0, idx_reg};
				end
			end
			default: begin
				push = 1'b0;
			end
		endcase
	end

	assign advance      = !fifo_full;
	assign key_down_evt = push && advance && (walk_reg == KMS_WALK_NEW);

	// Event walker sequence and key slots.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			walk_reg     <= KMS_WALK_IDLE;
			idx_reg      <= '0;
			eff_snap_reg <= '0;
			sf_snap_reg  <= '0;
			slot_vld_reg <= '0;
			for (int k = 0; k < 3; k++) begin
				slot_key_reg[k] <= '0;
			end
		end else begin
			case (walk_reg)
				KMS_WALK_IDLE: begin
					if (upd) begin
						eff_snap_reg <= eff;
						sf_snap_reg  <= stable[71:64];
						idx_reg      <= '0;
						walk_reg     <= KMS_WALK_SLOT;
					end
				end
				KMS_WALK_SLOT: begin
					if (advance) begin
						if (push) begin
							slot_vld_reg[idx_reg[1:0]] <= 1'b0;
						end
						idx_reg  <= (idx_reg == 6'd2) ? 6'd0 : idx_reg + 1'b1;
						walk_reg <= (idx_reg == 6'd2) ? KMS_WALK_NEW : KMS_WALK_SLOT;
					end
				end
				KMS_WALK_NEW: begin
					if (advance) begin
						if (push) begin
							slot_vld_reg[free_sel] <= 1'b1;
							slot_key_reg[free_sel] <= idx_reg;
						end
						idx_reg <= idx_reg + 1'b1;
						if (idx_reg == 6'd63) begin
							walk_reg <= KMS_WALK_IDLE;
						end
					end
				end
				default: begin
					walk_reg <= KMS_WALK_IDLE;
				end
			endcase
		end
	end

	// Unread key events.
	kms_event_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_event_fifo (
		.clock_i (clock_i),
		.rst_n_i (rst_n),
		.push_i  (push && advance),
		.data_i  (push_data),
		.full_o  (fifo_full),
		.pop_i   (data_rd && fifo_valid),
		.valid_o (fifo_valid),
		.head_o  (fifo_head)
	);

	assign data_rd = reg_rd_i && (reg_addr_i == `KMS_ADDR_KEY_DATA);

	// Register reads; a key data read takes one event.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`KMS_ADDR_COMBO0:   reg_rdata_o <= combo_mask_reg[0];
				`KMS_ADDR_COMBO1:   reg_rdata_o <= combo_mask_reg[1];
				`KMS_ADDR_COMBO2:   reg_rdata_o <= combo_mask_reg[2];
				`KMS_ADDR_KEY_DATA: reg_rdata_o <= fifo_valid ? fifo_head : `KMS_EVT_NO_KEY;
				default:            reg_rdata_o <= `KMS_RD_UNMAPPED;
			endcase
		end
	end

	// combination flag; a new hit wins over the clearing read.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			combo_prev_reg    <= 1'b0;
			combo_pending_reg <= 1'b0;
		end else begin
			if (upd) begin
				combo_prev_reg <= combo_hit;
			end
			if (combo_rise) begin
				combo_pending_reg <= 1'b1;
			end else if (data_rd) begin
				combo_pending_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= fifo_valid || combo_pending_reg;
		end
	end

	// wake requests from sleep and hibernate.
	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			wake_o        <= 1'b0;
			sleep_req_o   <= 1'b0;
			hib_return_o  <= 1'b0;
			hib_probe_reg <= 1'b0;
		end else begin
			wake_o       <= 1'b0;
			sleep_req_o  <= 1'b0;
			hib_return_o <= 1'b0;
			if (in_hib && hibernate_wake_enable_i && scanner_clock_enable_i
				&& (col_low != 8'h00) && !hib_probe_reg) begin
				sleep_req_o   <= 1'b1;
				hib_probe_reg <= 1'b1;
			end else if (in_sleep && (key_down_evt || combo_rise)) begin
				wake_o        <= 1'b1;
				hib_probe_reg <= 1'b0;
			end else if (in_sleep && hib_probe_reg && upd && stable == 72'h0) begin
				hib_return_o  <= 1'b1;
				hib_probe_reg <= 1'b0;
			end else if (power_mode_i == KMS_PWR_OPER) begin
				hib_probe_reg <= 1'b0;
			end
		end
	end

endmodule : kms_scanner

// ---- kms_scanner_properties.sv ----
// Port checks of the key matrix scanner.
`timescale 1ns/1ps
`include "kms_defines.svh"

module kms_scanner_properties #(
	parameter int TICK_CYC   = 100,
	parameter int FIFO_DEPTH = 8
) (
	// Clock, reset and register strobes
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_rd_i,
	// Configuration and power mode
	input wire logic       scanner_clock_enable_i,
	input wire logic [2:0] dedicated_key_enable_i,
	input wire logic [7:0] column_scan_enable_i,
	input wire logic [7:0] row_scan_enable_i,
	input wire logic       hibernate_wake_enable_i,
	input wire logic [1:0] power_mode_i,
	// Pins and status
	input wire logic [7:0] col_i,
	input wire logic [7:0] row_oe_n_o,
	input wire logic [7:0] col_pullup_o,
	input wire logic [7:0] row_dir_out_o,
	input wire logic       irq_o,
	input wire logic       wake_o,
	input wire logic       sleep_req_o,
	input wire logic       hib_return_o,
	input wire logic [2:0] ded_key_up_o
);
	logic [2:0] rel_cnt_reg;
	logic       ready;
	logic       rd_key;
	logic       hib_act;

	// Edges since reset release.
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rel_cnt_reg <= 3'h0;
		end else if (rel_cnt_reg != 3'h4) begin
			rel_cnt_reg <= rel_cnt_reg + 3'h1;
		end
	end

	// Property causes.
	assign ready   = (rel_cnt_reg == 3'h4);
	assign rd_key  = reg_rd_i && (reg_addr_i == `KMS_ADDR_KEY_DATA);
	assign hib_act = ready && (power_mode_i == 2'h2) && hibernate_wake_enable_i
		&& scanner_clock_enable_i && ((~col_i & column_scan_enable_i) != 8'h00);

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_hib_activity;
		$rose(hib_act);
	endsequence

	sequence s_rows_settled;
		ready ##1 $stable(row_scan_enable_i) [*3];
	endsequence

	AST_COL_PULLUP: assert property (ready |-> col_pullup_o == $past(column_scan_enable_i))
		else $error("Column pull-ups do not follow the enabled columns");
	AST_ROW_DIR: assert property (ready |-> row_dir_out_o == $past(row_scan_enable_i))
		else $error("Row directions do not follow the enabled rows");
	AST_ROW_ENABLED: assert property (s_rows_settled |-> (~row_oe_n_o & ~row_scan_enable_i) == 8'h00)
		else $error("A disabled row is driven");
	AST_CLOCK_GATED: assert property (ready && !$past(scanner_clock_enable_i)
		&& !$past(scanner_clock_enable_i, 2) |-> !sleep_req_o && !hib_return_o)
		else $error("Scanner acted with its clock disabled");
	AST_WAKE_PULSE: assert property (wake_o |=> !wake_o)
		else $error("Wake pulse longer than one cycle");
	AST_SLEEP_ON_ACTIVITY: assert property (s_hib_activity |=> sleep_req_o)
		else $error("Column activity in hibernate gave no sleep request");
	AST_SLEEP_CAUSE: assert property (sleep_req_o |-> $past(hib_act))
		else $error("Sleep request without hibernate column activity");
	AST_RETURN_FROM_SLEEP: assert property (hib_return_o |-> $past(power_mode_i) == 2'h1)
		else $error("Return to hibernate outside sleep");
	AST_IRQ_HELD: assert property ($fell(irq_o) |-> $past(rd_key, 2) || $past(rd_key, 3)
		|| $past(rd_key, 4))
		else $error("Interrupt dropped without a key data read");
	AST_DEDICATED: assert property (ready && $past(scanner_clock_enable_i)
		|-> (ded_key_up_o & $past(dedicated_key_enable_i))
		== ($past(col_i[2:0]) & $past(dedicated_key_enable_i)))
		else $error("Dedicated key state does not follow its column");
endmodule : kms_scanner_properties

bind kms_scanner kms_scanner_properties #(.TICK_CYC(TICK_CYC), .FIFO_DEPTH(FIFO_DEPTH)) u_props (
	.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_rd_i(reg_rd_i),
	.scanner_clock_enable_i(scanner_clock_enable_i), .dedicated_key_enable_i(dedicated_key_enable_i),
	.column_scan_enable_i(column_scan_enable_i), .row_scan_enable_i(row_scan_enable_i),
	.hibernate_wake_enable_i(hibernate_wake_enable_i), .power_mode_i(power_mode_i),
	.col_i(col_i), .row_oe_n_o(row_oe_n_o), .col_pullup_o(col_pullup_o),
	.row_dir_out_o(row_dir_out_o), .irq_o(irq_o), .wake_o(wake_o), .sleep_req_o(sleep_req_o),
	.hib_return_o(hib_return_o), .ded_key_up_o(ded_key_up_o)
);

// ---- tb.sv ----
// Self-checking bench for the key matrix scanner.
`timescale 1ns/1ps
`include "kms_defines.svh"

module tb;
	// Scanner inputs
	logic        clock_i, rst_n_i, reg_wr_i, reg_rd_i, scanner_clock_enable_i, scan_enable_i;
	logic        hibernate_wake_enable_i;
	logic [1:0]  power_mode_i;
	logic [2:0]  dedicated_key_enable_i;
	logic [3:0]  scan_count_i, debounce_count_i;
	logic [7:0]  reg_addr_i, reg_wdata_i, column_scan_enable_i, row_scan_enable_i;
	// Scanner outputs and column wires
	logic [7:0]  reg_rdata_o, col_i, row_o, row_oe_n_o, col_pullup_o, row_dir_out_o, sf_key_up_o;
	logic [2:0]  ded_key_up_o;
	logic        irq_o, wake_o, sleep_req_o, hib_return_o;
	// Key state and bookkeeping
	logic [63:0] keys;
	logic [7:0]  lines;
	int          fail_count, n_compared, cycles;

	// Short tick keeps frames brief.
	kms_scanner #(.TICK_CYC(2), .FIFO_DEPTH(8)) uut (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.scanner_clock_enable_i(scanner_clock_enable_i), .scan_enable_i(scan_enable_i),
		.scan_count_i(scan_count_i), .debounce_count_i(debounce_count_i),
		.dedicated_key_enable_i(dedicated_key_enable_i),
		.column_scan_enable_i(column_scan_enable_i), .row_scan_enable_i(row_scan_enable_i),
		.hibernate_wake_enable_i(hibernate_wake_enable_i), .power_mode_i(power_mode_i),
		.col_i(col_i), .row_o(row_o), .row_oe_n_o(row_oe_n_o), .col_pullup_o(col_pullup_o),
		.row_dir_out_o(row_dir_out_o), .irq_o(irq_o), .wake_o(wake_o), .sleep_req_o(sleep_req_o),
		.hib_return_o(hib_return_o), .sf_key_up_o(sf_key_up_o), .ded_key_up_o(ded_key_up_o)
	);

	// Keypad model.
	kms_keypad_model u_pad (.row_i(row_o), .row_oe_n_i(row_oe_n_o), .key_down_i(keys),
		.line_low_i(lines), .col_o(col_i));

	// 100 MHz clock.
	always #5 clock_i = ~clock_i;

	// Hang guard.
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 40000) begin
			fail_count++;
			stop_test();
		end
	end

	function automatic logic [7:0] ev(input logic up, input logic [2:0] r, input logic [2:0] c);
		return {up, 1'b0, r, c};
	endfunction : ev

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One-cycle write strobe.
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_wr_i    <= 1'b1;
		@(posedge clock_i);
		reg_wr_i <= 1'b0;
		@(posedge clock_i);
	endtask : reg_wr

	// Read; key data reads must be at least two cycles apart.
	task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		reg_addr_i <= a;
		reg_rd_i   <= 1'b1;
		@(posedge clock_i);
		reg_rd_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		check(reg_rdata_o, exp, what);
	endtask : reg_rd

	task automatic rd_key(input logic [7:0] exp, input string what);
		reg_rd(`KMS_ADDR_KEY_DATA, exp, what);
	endtask : rd_key

	// Bounded wait on irq, wake, sleep or return (sel 0..3).
	task automatic wait_sig(input int sel, input logic exp, input string what);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < 500 && !hit; i++) begin
			@(posedge clock_i);
			hit = ((sel == 0) ? irq_o : (sel == 1) ? wake_o : (sel == 2) ? sleep_req_o
				: hib_return_o) === 1'b1;
		end
		check({7'h00, hit}, {7'h00, exp}, what);
	endtask : wait_sig

	task automatic idle_irq(input string what);
		repeat (300) @(posedge clock_i);
		check({7'h00, irq_o}, 8'h00, what);
	endtask : idle_irq

	task automatic stop_test();
		$display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : stop_test

	// Test sequence.
	initial begin
		clock_i = 1'b0;
		{rst_n_i, reg_wr_i, reg_rd_i, scanner_clock_enable_i, scan_enable_i} = '0;
		{hibernate_wake_enable_i, power_mode_i, dedicated_key_enable_i} = '0;
		{scan_count_i, debounce_count_i, reg_addr_i, reg_wdata_i} = '0;
		{column_scan_enable_i, row_scan_enable_i, lines, keys} = '0;
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		for (int i = 0; i < 3; i++) reg_rd(8'h65 + i[7:0], `KMS_COMBO_RESET, "combo reset");
		reg_rd(8'h10, `KMS_RD_UNMAPPED, "unmapped");
		rd_key(`KMS_EVT_NO_KEY, "empty data");
		for (int i = 0; i < 3; i++) begin
			reg_wr(8'h65 + i[7:0], 8'h3f - i[7:0]);
			reg_rd(8'h65 + i[7:0], 8'h3f - i[7:0], "combo rw");
		end
		{scan_count_i, debounce_count_i, column_scan_enable_i, row_scan_enable_i} <= 24'h01ffff;
		keys[21] <= 1'b1;
		idle_irq("clock off");
		scanner_clock_enable_i <= 1'b1;
		idle_irq("scan off");
		scan_enable_i <= 1'b1;
		wait_sig(0, 1'b1, "irq on key");
		rd_key(ev(0, 3'd2, 3'd5), "key down");
		repeat (2) @(posedge clock_i);
		check({7'h00, irq_o}, 8'h00, "irq after read");
		keys <= 64'h0;
		wait_sig(0, 1'b1, "irq on release");
		rd_key(ev(1, 3'd2, 3'd5), "key up");
		keys <= 64'h0000_4000_1000_0402;
		repeat (300) @(posedge clock_i);
		rd_key(ev(0, 3'd0, 3'd1), "first of four");
		rd_key(ev(0, 3'd1, 3'd2), "second of four");
		rd_key(ev(0, 3'd3, 3'd4), "third of four");
		rd_key(`KMS_EVT_NO_KEY, "fourth ignored");
		keys <= 64'h0;
		repeat (300) @(posedge clock_i);
		rd_key(ev(1, 3'd0, 3'd1), "up 1");
		rd_key(ev(1, 3'd1, 3'd2), "up 2");
		rd_key(ev(1, 3'd3, 3'd4), "up 3");
		{column_scan_enable_i, row_scan_enable_i} <= 16'h7f7f;
		keys <= 64'h0100_0000_0000_0080;
		idle_irq("disabled lines");
		{column_scan_enable_i, row_scan_enable_i} <= 16'hffff;
		keys <= 64'h0000_0000_0008_0000;
		wait_sig(0, 1'b1, "irq matrix key");
		rd_key(ev(0, 3'd2, 3'd3), "matrix down");
		lines[3] <= 1'b1;
		wait_sig(0, 1'b1, "irq special down");
		check(sf_key_up_o, 8'hf7, "special state");
		rd_key(`KMS_EVT_NO_KEY, "masked key");
		lines[3] <= 1'b0;
		wait_sig(0, 1'b1, "irq special up");
		rd_key(ev(0, 3'd2, 3'd3), "fresh down");
		lines[3] <= 1'b1;
		wait_sig(0, 1'b1, "irq special again");
		rd_key(`KMS_EVT_NO_KEY, "masked again");
		keys <= 64'h0;
		idle_irq("release under special");
		lines[3] <= 1'b0;
		idle_irq("special released");
		dedicated_key_enable_i <= 3'h1;
		lines[0] <= 1'b1;
		repeat (4) @(posedge clock_i);
		check({5'h00, ded_key_up_o}, 8'h06, "dedicated down");
		lines[0] <= 1'b0;
		repeat (4) @(posedge clock_i);
		check({5'h00, ded_key_up_o}, 8'h07, "dedicated up");
		dedicated_key_enable_i <= 3'h0;
		reg_wr(8'h65, 8'h11);
		reg_wr(8'h66, 8'h2a);
		reg_wr(8'h67, `KMS_COMBO_NONE);
		keys <= 64'h0040_0400_0002_0000;
		repeat (300) @(posedge clock_i);
		rd_key(ev(0, 3'd2, 3'd1), "combo key a");
		rd_key(ev(0, 3'd5, 3'd2), "combo key b");
		rd_key(ev(0, 3'd6, 3'd6), "extra key");
		power_mode_i <= 2'h1;
		wait_sig(1, 1'b0, "extra key blocks wake");
		keys[54] <= 1'b0;
		wait_sig(1, 1'b1, "combination wake");
		repeat (2) @(posedge clock_i);
		check({7'h00, irq_o}, 8'h01, "combination irq");
		keys <= 64'h0;
		power_mode_i <= 2'h0;
		repeat (300) @(posedge clock_i);
		rd_key(ev(1, 3'd6, 3'd6), "extra up");
		rd_key(ev(1, 3'd2, 3'd1), "combo a up");
		rd_key(ev(1, 3'd5, 3'd2), "combo b up");
		hibernate_wake_enable_i <= 1'b1;
		power_mode_i <= 2'h2;
		repeat (5) @(posedge clock_i);
		keys[36] <= 1'b1;
		wait_sig(2, 1'b1, "hibernate activity");
		power_mode_i <= 2'h1;
		wait_sig(1, 1'b1, "wake on key");
		power_mode_i <= 2'h0;
		repeat (300) @(posedge clock_i);
		rd_key(ev(0, 3'd4, 3'd4), "wake key");
		keys <= 64'h0;
		repeat (300) @(posedge clock_i);
		rd_key(ev(1, 3'd4, 3'd4), "wake key up");
		power_mode_i <= 2'h2;
		repeat (5) @(posedge clock_i);
		keys[36] <= 1'b1;
		@(posedge clock_i);
		keys[36] <= 1'b0;
		wait_sig(2, 1'b1, "short activity");
		power_mode_i <= 2'h1;
		wait_sig(3, 1'b1, "back to hibernate");
		stop_test();
	end
endmodule : tb
